// >>> core/exc_entry.sv
// Exception entry logic for system reset and machine check.
module exc_entry
    import exc_entry_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  soft_reset_in_n,
    input  wire logic                  hard_reset_in_n,
    input  wire logic                  machine_check_input_n,
    input  wire logic                  bus_transfer_error_n,
    input  wire logic                  bus_op_own,
    input  wire logic                  addr_parity_err,
    input  wire logic                  data_parity_err,
    input  wire logic                  icache_parity_err,
    input  wire logic                  dcache_parity_err,
    input  wire logic                  state_corrupt,
    input  wire logic                  recoverable_state_bit,
    input  wire logic                  take_ready,
    input  wire logic                  me_wr,
    input  wire logic                  me_wdata,
    output logic                       exc_take,
    output logic [`EXC_VEC_W-1:0]      exc_vector,
    output logic                       saved_ri,
    output logic                       machine_check_enable,
    output logic                       checkstop
);
    import exc_entry_pkg::*;

    exc_state_t  st_r;
    exc_state_t  st_nxt;
    logic [4:0]  pins_raw;
    logic [4:0]  pins_s;
    logic        rst_lvl;
    logic        mcp_lvl;
    logic        tea_lvl;
    logic        rst_evt;
    logic        mchk_evt;
    logic        parity_evt;
    logic        pend_any;
    logic        ri_keep;

    localparam exc_state_t ST_RESET = '{
        fsm:       ST_RUN,
        rst_prev:  1'b0,
        mcp_prev:  1'b0,
        pend_rst:  1'b0,
        pend_mchk: 1'b0,
        corrupt:   1'b0,
        me:        `EXC_ME_RESET,
        ckstop:    1'b0,
        take:      1'b0,
        vector:    `EXC_VEC_NONE,
        saved_ri:  1'b0
    };

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The synchroniser below is built with exactly two stages.
    if (`EXC_SYNC_STAGES != 2) begin : g_bad_sync
        $error("exc_entry: synchroniser depth must be two");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // The ownership flag travels with the transfer error through the
    // same two stages, so both are seen in the same cycle.
    assign pins_raw = {bus_op_own,
                       ~soft_reset_in_n,
                       ~hard_reset_in_n,
                       ~machine_check_input_n,
                       ~bus_transfer_error_n};

    pin_sync #(
        .W       (5)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .d       (pins_raw),
        .rst_val (5'h00),
        .q       (pins_s)
    );

    assign rst_lvl = pins_s[3] | pins_s[2];
    assign mcp_lvl = pins_s[1];
    // Transfer error counts only during an operation we started.
    // qualify transfer error
    assign tea_lvl = pins_s[0] & pins_s[4];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // reset edge detect
    assign rst_evt    = rst_lvl & ~st_r.rst_prev;
    assign parity_evt = addr_parity_err | data_parity_err |
                        icache_parity_err | dcache_parity_err;
    // Transfer errors are pulses per beat, so they are not edge detected.
    // machine check sources
    assign mchk_evt   = (mcp_lvl & ~st_r.mcp_prev) | tea_lvl | parity_evt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Conditions are latched as pending and taken when the core can
    // accept them; no link to a particular instruction is kept.
    // imprecise pending latch
    always_comb begin
        st_nxt           = st_r;
        pend_any         = 1'b0;
        ri_keep          = 1'b0;
        st_nxt.rst_prev  = rst_lvl;
        st_nxt.mcp_prev  = mcp_lvl;
        st_nxt.take      = 1'b0;
        if (me_wr) begin
            st_nxt.me = me_wdata;
        end
        st_nxt.pend_rst  = st_r.pend_rst | rst_evt;
        st_nxt.pend_mchk = st_r.pend_mchk | mchk_evt;
        pend_any         = st_nxt.pend_rst | st_nxt.pend_mchk;
        // Corruption is only remembered while an entry is pending, so a
        // stale report from an idle period cannot spoil a later entry.
        st_nxt.corrupt   = (st_r.corrupt | state_corrupt) & pend_any;
        ri_keep          = recoverable_state_bit &
                           ~(st_r.corrupt | state_corrupt);
        case (st_r.fsm)
            ST_RUN: begin
                if (st_nxt.pend_rst) begin
                    if (take_ready) begin
                        st_nxt.take      = 1'b1;
                        st_nxt.vector    = `EXC_VEC_RESET;
                        st_nxt.me        = 1'b0;
                        st_nxt.saved_ri  = ri_keep;
                        st_nxt.corrupt   = 1'b0;
                        st_nxt.pend_rst  = 1'b0;
                        // A reset restarts the core, so an older machine
                        // check has nothing left to report against.
                        st_nxt.pend_mchk = 1'b0;
                    end
                end else if (st_nxt.pend_mchk) begin
                    if (!st_r.me) begin
                        st_nxt.fsm       = ST_CHECKSTOP;
                        st_nxt.ckstop    = 1'b1;
                        st_nxt.pend_mchk = 1'b0;
                        st_nxt.corrupt   = 1'b0;
                    end else if (take_ready) begin
                        st_nxt.take      = 1'b1;
                        st_nxt.vector    = `EXC_VEC_MCHK;
                        st_nxt.me        = 1'b0;
                        st_nxt.saved_ri  = ri_keep;
                        st_nxt.corrupt   = 1'b0;
                        st_nxt.pend_mchk = 1'b0;
                    end
                end
            end
            ST_CHECKSTOP: begin
                // Only a system reset leaves the checkstop state.
                st_nxt.pend_mchk = 1'b0;
                if (st_nxt.pend_rst && take_ready) begin
                    st_nxt.fsm      = ST_RUN;
                    st_nxt.ckstop   = 1'b0;
                    st_nxt.take     = 1'b1;
                    st_nxt.vector   = `EXC_VEC_RESET;
                    st_nxt.me       = 1'b0;
                    st_nxt.saved_ri = ri_keep;
                    st_nxt.corrupt  = 1'b0;
                    st_nxt.pend_rst = 1'b0;
                end
            end
            default: begin
                st_nxt.fsm = ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign exc_take             = st_r.take;
    assign exc_vector           = st_r.vector;
    assign saved_ri             = st_r.saved_ri;
    assign machine_check_enable = st_r.me;
    assign checkstop            = st_r.ckstop;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_rst_take;
        exc_take && (exc_vector == `EXC_VEC_RESET);
    endsequence

    sequence s_mchk_take;
        exc_take && (exc_vector == `EXC_VEC_MCHK);
    endsequence

    sequence s_mchk_run;
        mchk_evt && !rst_evt && !st_r.pend_rst && (st_r.fsm == ST_RUN);
    endsequence

    AST_RESET_TAKEN: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (rst_evt && take_ready) |=> s_rst_take
    ) else $error("system reset was not taken at its vector");

    AST_MCHK_TAKEN: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_mchk_run ##0 (st_r.me && take_ready) |=> s_mchk_take
    ) else $error("machine check was not taken at its vector");

    AST_CHECKSTOP: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_mchk_run ##0 !st_r.me |=> (checkstop && !exc_take)
    ) else $error("disabled machine check did not checkstop");

    AST_ME_CLEAR: assert property (
        @(posedge mclk) disable iff (!reset_n)
        exc_take |-> !machine_check_enable
    ) else $error("enable bit still set after exception entry");

    AST_RI_CLEAR: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (exc_take && $past(state_corrupt)) |-> !saved_ri
    ) else $error("saved recoverable bit kept despite corruption");

    AST_PARITY: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (parity_evt && !rst_evt && !st_r.pend_rst &&
         (st_r.fsm == ST_RUN) && take_ready)
        |=> (s_mchk_take or checkstop)
    ) else $error("parity error raised no machine check");

    AST_PRIORITY: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (rst_evt && mchk_evt && take_ready) |=> s_rst_take
    ) else $error("machine check taken ahead of system reset");
endmodule : exc_entry

// >>> core/exc_entry_params.svh
// Constants for the reset and machine-check exception entry logic.
`ifndef EXC_ENTRY_PARAMS_SVH
`define EXC_ENTRY_PARAMS_SVH

`define EXC_VEC_W        20
`define EXC_VEC_RESET    20'h00100
`define EXC_VEC_MCHK     20'h00200
`define EXC_VEC_NONE     20'h00000
`define EXC_ME_RESET     1'b0
`define EXC_SYNC_STAGES  2

`endif

// >>> core/exc_entry_pkg.sv
// Types shared by the exception entry logic.
package exc_entry_pkg;
`include "exc_entry_params.svh"

    typedef enum logic [0:0] {
        ST_RUN,
        ST_CHECKSTOP
    } exc_fsm_t;

    typedef struct packed {
        exc_fsm_t               fsm;
        logic                   rst_prev;
        logic                   mcp_prev;
        logic                   pend_rst;
        logic                   pend_mchk;
        logic                   corrupt;
        logic                   me;
        logic                   ckstop;
        logic                   take;
        logic [`EXC_VEC_W-1:0]  vector;
        logic                   saved_ri;
    } exc_state_t;

endpackage : exc_entry_pkg

// >>> core/pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // A zero-width bundle has nothing to carry.
    if (W < 1) begin : g_bad_width
        $error("pin_sync: width must be at least one");
    end

    // The first stage feeds only the second stage.
    always_comb begin
        st_nxt.meta   = d;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= {rst_val, rst_val};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;
endmodule : pin_sync

// >>> sim/mem_err_model.sv
// Memory controller model reporting bus errors.
module mem_err_model (
    input  wire logic mclk,
    input  wire logic fault,
    output logic      bus_transfer_error_n,
    output logic      bus_op_own
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge mclk) begin
        bus_op_own           <= fault;
        bus_transfer_error_n <= !fault;
    end
endmodule : mem_err_model

// >>> sim/tb_top.sv
// Self-checking bench for the exception entry logic.
`include "exc_entry_params.svh"
module tb_top;
    import exc_entry_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] ev; logic [`EXC_VEC_W-1:0] v;} row_t;
    logic mclk = 0, reset_n = 0, cor = 0, me_wr = 0, me_wd = 0;
    logic [7:0] ev = '0;
    logic take, sri, mce, ckst, tea_n, own;
    logic [`EXC_VEC_W-1:0] vec;
    int err_count = 0, checked = 0;
    row_t rows[8] = '{'{8'h01, `EXC_VEC_RESET}, '{8'h02, `EXC_VEC_RESET},
        '{8'h04, `EXC_VEC_MCHK}, '{8'h08, `EXC_VEC_MCHK},
        '{8'h10, `EXC_VEC_MCHK}, '{8'h20, `EXC_VEC_MCHK},
        '{8'h40, `EXC_VEC_MCHK}, '{8'h80, `EXC_VEC_MCHK}};
    mem_err_model i_mem (.mclk(mclk), .fault(ev[3]),
        .bus_transfer_error_n(tea_n), .bus_op_own(own));
    exc_entry i_dut (.mclk(mclk), .reset_n(reset_n),
        .soft_reset_in_n(!ev[0]), .hard_reset_in_n(!ev[1]),
        .machine_check_input_n(!ev[2]), .bus_transfer_error_n(tea_n),
        .bus_op_own(own), .addr_parity_err(ev[4]),
        .data_parity_err(ev[5]), .icache_parity_err(ev[6]),
        .dcache_parity_err(ev[7]), .state_corrupt(cor),
        .recoverable_state_bit(1'b1), .take_ready(1'b1),
        .me_wr(me_wr), .me_wdata(me_wd), .exc_take(take),
        .exc_vector(vec), .saved_ri(sri),
        .machine_check_enable(mce), .checkstop(ckst));
    initial forever #12.5 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Writes the enable bit, raises the events and waits for an outcome.
    task automatic fire(input logic [7:0] e, input logic me, c);
        int n;
        @(posedge mclk) begin
            me_wr <= 1'b1;
            me_wd <= me;
        end
        @(posedge mclk) begin
            me_wr <= 1'b0;
            ev    <= e;
            cor   <= c;
        end
        // Error reports are single-cycle pulses, as on the bus.
        @(posedge mclk) ev <= '0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (take !== 1'b1 && ckst !== 1'b1 && n < 40);
        chk("outcome", n < 40, 1);
    endtask : fire
    task automatic idle;
        @(posedge mclk) ev <= '0;
        repeat (20) @(posedge mclk);
    endtask : idle
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk("ckstop_rst", ckst, 0);
        chk("enable_rst", mce, `EXC_ME_RESET);
        chk("take_rst", take, 0);
        foreach (rows[i]) begin
            fire(rows[i].ev, 1'b1, 1'b1);
            chk("vector", vec, rows[i].v);
            chk("enable", mce, 0);
            chk("saved_ri", sri, 0);
            idle();
            $display("test %0d done", i);
        end
        fire(8'h05, 1'b1, 1'b0);
        chk("priority", vec, `EXC_VEC_RESET);
        chk("saved_ri_ok", sri, 1);
        idle();
        fire(8'h04, 1'b0, 1'b0);
        chk("checkstop", ckst, 1);
        chk("no_take", take, 0);
        @(posedge mclk) reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk("ckstop_rerst", ckst, 0);
        chk("enable_rerst", mce, `EXC_ME_RESET);
        $display("awkward tests done");
        final_report();
    end
    initial begin
        repeat (1500) @(posedge mclk);
        err_count++;
        final_report();
    end
endmodule : tb_top
